/* shared/dss_pkg.sv */
package dss_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 25000;
    localparam int WAKE_LOW_MIN_NS   = 500;
    localparam int WAKE_LOW_MIN_CYC  =
        (WAKE_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OSC_SETTLE_CYC    = 64;
    localparam int CLK_STOP_GAP_CYC  = 2;
    localparam int REF_CLK_MHZ       = 24;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_ARM  = 1'h0;
    localparam logic RST_DONE = 1'h0;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DSS_RUN,
        DSS_CLK_STOP,
        DSS_OSC_OFF,
        DSS_SLEEP,
        DSS_OSC_SETTLE,
        DSS_CLK_START
    } dss_state_t;

endpackage

/* core/dss_deep_sleep_sequencer.sv */
`timescale 1ns/1ps

module dss_deep_sleep_sequencer
    import dss_pkg::*;
#(
    parameter int N_MOD      = 8,
    parameter int SETTLE_CYC = OSC_SETTLE_CYC
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_sleep_wake_pin,
    input  wire logic             i_sleep_arm_bit,
    input  wire logic             i_wfi_req,
    input  wire logic             i_irq_pending,
    input  wire logic [N_MOD-1:0] i_mod_clk_en,
    input  wire logic [N_MOD-1:0] i_mod_keep_on,
    input  wire logic             i_pll_bypass,
    input  wire logic             i_pll_pwr_off_req,
    output logic                  o_sleep_done_flag,
    output logic                  o_clk_run,
    output logic                  o_osc_pwr_on,
    output logic                  o_core_clk_en,
    output logic [N_MOD-1:0]      o_mod_clk_en,
    output logic                  o_pll_sel_ref,
    output logic                  o_pll_pwr_on,
    output logic                  o_in_deep_sleep
);

    // ------------------------------------------------------------
    // Pin synchroniser and edge detect
    // ------------------------------------------------------------
    logic       pin_m;
    logic       pin_s;
    logic       pin_d;
    logic       next_pin_m;
    logic       next_pin_s;
    logic       next_pin_d;
    logic       pin_fall;
    logic       pin_rise;

    // Two flops before any logic, then one delay for edges
    always_comb begin
        next_pin_m = i_sleep_wake_pin;
        next_pin_s = pin_m;
        next_pin_d = pin_s;
    end

    // Pin flops idle high so reset gives no false edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_m <= 1'h1;
            pin_s <= 1'h1;
            pin_d <= 1'h1;
        end else begin
            pin_m <= next_pin_m;
            pin_s <= next_pin_s;
            pin_d <= next_pin_d;
        end
    end

    assign pin_fall = pin_d & ~pin_s;
    assign pin_rise = ~pin_d & pin_s;

    // ------------------------------------------------------------
    // Deep sleep sequencer
    // ------------------------------------------------------------
    localparam int CW = $clog2(SETTLE_CYC + CLK_STOP_GAP_CYC + 1);

    dss_state_t    state;
    dss_state_t    next_state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          done;
    logic          next_done;
    logic          wake_pend;
    logic          next_wake_pend;

    // ------------------------------------------------------------
    // Step counter and state decode
    // ------------------------------------------------------------
    // Counter step toward zero; holds at zero
    function automatic logic [CW-1:0] dss_count_down(input logic [CW-1:0] value);
        logic [CW-1:0] result;
        result = value;
        if (value != '0) begin
            result = value - CW'(1);
        end
        return result;
    endfunction

    // Terminal count of the step counter
    function automatic logic dss_count_done(input logic [CW-1:0] value);
        return (value == '0);
    endfunction

    // Device clocks run only in the awake state
    function automatic logic dss_clocks_on(input dss_state_t st);
        return (st == DSS_RUN);
    endfunction

    // Oscillators are off from power-down until the wake edge
    function automatic logic dss_osc_on(input dss_state_t st);
        return (st != DSS_OSC_OFF) && (st != DSS_SLEEP);
    endfunction

    // Between the entry edge and the sleep state
    function automatic logic dss_entering(input dss_state_t st);
        return (st == DSS_CLK_STOP) || (st == DSS_OSC_OFF);
    endfunction

    // Core clock runs with device clocks unless waiting for an interrupt
    function automatic logic dss_core_on(input logic run, input logic waiting);
        return run && !waiting;
    endfunction

    // Requested and kept-on modules run while device clocks run
    function automatic logic [N_MOD-1:0] dss_mod_enables(
        input logic             run,
        input logic [N_MOD-1:0] req,
        input logic [N_MOD-1:0] keep
    );
        return run ? (req | keep) : '0;
    endfunction

    // PLL stays powered unless bypassed with power-off asked, or oscillators off
    function automatic logic dss_pll_on(
        input logic bypass,
        input logic off_req,
        input logic osc_on
    );
        return !(bypass && off_req) && osc_on;
    endfunction

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    // Step on pin edges; ordered clock/oscillator handling
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_done  = done;
        unique case (state)
            DSS_RUN: begin
                if (pin_fall && i_sleep_arm_bit) begin
                    next_state = DSS_CLK_STOP;
                    next_cnt   = CW'(CLK_STOP_GAP_CYC);
                end
            end
            DSS_CLK_STOP: begin
                // Clocks already off; wait before dropping oscillators
                if (dss_count_done(cnt)) begin
                    next_state = DSS_OSC_OFF;
                end else begin
                    next_cnt = dss_count_down(cnt);
                end
            end
            DSS_OSC_OFF: begin
                next_state = DSS_SLEEP;
            end
            DSS_SLEEP: begin
                if (pin_rise || wake_pend) begin
                    next_state = DSS_OSC_SETTLE;
                    next_cnt   = CW'(SETTLE_CYC);
                end
            end
            DSS_OSC_SETTLE: begin
                if (dss_count_done(cnt)) begin
                    next_state = DSS_CLK_START;
                end else begin
                    next_cnt = dss_count_down(cnt);
                end
            end
            DSS_CLK_START: begin
                next_state = DSS_RUN;
                next_done  = ~done;
            end
            default: begin
                next_state = DSS_RUN;
            end
        endcase
    end

    // No state is cleared on wakeup, only on system reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= DSS_RUN;
            cnt   <= '0;
            done  <= RST_DONE;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            done  <= next_done;
        end
    end

    // ------------------------------------------------------------
    // Early wake capture
    // ------------------------------------------------------------
    // Keeps a rising edge that lands before sleep so the machine cannot hang
    always_comb begin
        next_wake_pend = wake_pend;
        if (pin_rise && dss_entering(state)) begin
            next_wake_pend = 1'h1;  // Set wins over the clear
        end else if (!dss_entering(state)) begin
            next_wake_pend = 1'h0;
        end
    end

    // Pending wake register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wake_pend <= 1'h0;
        end else begin
            wake_pend <= next_wake_pend;
        end
    end

    // ------------------------------------------------------------
    // Wait-for-interrupt core gating
    // ------------------------------------------------------------
    logic wfi;
    logic next_wfi;

    // Enter on request, leave on an enabled interrupt
    always_comb begin
        next_wfi = wfi;
        if (wfi && i_irq_pending) begin
            next_wfi = 1'h0;
        end else if (i_wfi_req && !i_irq_pending) begin
            next_wfi = 1'h1;
        end
    end

    // Wait-for-interrupt state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wfi <= 1'h0;
        end else begin
            wfi <= next_wfi;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    logic             clks_on;
    logic             next_clk_run;
    logic             next_osc_pwr_on;
    logic             next_core_clk_en;
    logic [N_MOD-1:0] next_mod_clk_en;
    logic             next_pll_sel_ref;
    logic             next_pll_pwr_on;
    logic             next_in_deep_sleep;

    // Clock and power enables derived from next state
    always_comb begin
        clks_on          = dss_clocks_on(next_state);
        next_clk_run     = clks_on;
        next_osc_pwr_on  = dss_osc_on(next_state);
        next_core_clk_en = dss_core_on(clks_on, next_wfi);
        // Gated modules simply freeze; kept-on ones run under WFI
        next_mod_clk_en  = dss_mod_enables(clks_on, i_mod_clk_en,
                                           i_mod_keep_on);
        next_pll_sel_ref = i_pll_bypass;
        // PLL may only be off while bypassed or while the oscillators are off
        next_pll_pwr_on  = dss_pll_on(i_pll_bypass, i_pll_pwr_off_req,
                                      next_osc_pwr_on);
        next_in_deep_sleep = (next_state == DSS_SLEEP);
    end

    // Every output straight from a flop
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sleep_done_flag <= RST_DONE;
            o_clk_run         <= 1'h1;
            o_osc_pwr_on      <= 1'h1;
            o_core_clk_en     <= 1'h1;
            o_mod_clk_en      <= '1;
            o_pll_sel_ref     <= 1'h0;
            o_pll_pwr_on      <= 1'h1;
            o_in_deep_sleep   <= 1'h0;
        end else begin
            o_sleep_done_flag <= next_done;
            o_clk_run         <= next_clk_run;
            o_osc_pwr_on      <= next_osc_pwr_on;
            o_core_clk_en     <= next_core_clk_en;
            o_mod_clk_en      <= next_mod_clk_en;
            o_pll_sel_ref     <= next_pll_sel_ref;
            o_pll_pwr_on      <= next_pll_pwr_on;
            o_in_deep_sleep   <= next_in_deep_sleep;
        end
    end

endmodule

/* sim/dss_seq_assertions.sv */
`timescale 1ns/1ps
module dss_seq_assertions
    import dss_pkg::*;
#(
    parameter int N_MOD      = 8,
    parameter int SETTLE_CYC = OSC_SETTLE_CYC
) (
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic             i_sleep_wake_pin,
    input wire logic             i_sleep_arm_bit,
    input wire logic             i_wfi_req,
    input wire logic             i_irq_pending,
    input wire logic             o_sleep_done_flag,
    input wire logic             o_clk_run,
    input wire logic             o_osc_pwr_on,
    input wire logic             o_core_clk_en,
    input wire logic [N_MOD-1:0] o_mod_clk_en,
    input wire logic             o_in_deep_sleep
);
    // One clock domain, quiet in reset
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Entry and wakeup step orders
    sequence s_enter; ##[2:6] !o_clk_run ##[2:6] !o_osc_pwr_on ##[1:2] o_in_deep_sleep; endsequence
    sequence s_wake; ##[2:6] o_osc_pwr_on ##[1:80] $rose(o_clk_run); endsequence
    enter_seq_a: assert property (
        i_sleep_arm_bit && o_clk_run && $fell(i_sleep_wake_pin) |-> s_enter) else $error("entry");
    wake_seq_a: assert property (o_in_deep_sleep && $rose(i_sleep_wake_pin) |-> s_wake)
        else $error("wakeup");
    settle_first_a: assert property (
        !$past(i_rst) && $rose(o_clk_run) |-> $past(o_osc_pwr_on, SETTLE_CYC)) else $error("settle");
    run_osc_a: assert property (o_clk_run |-> o_osc_pwr_on) else $error("osc off");
    // Status flag and gating
    done_at_run_a: assert property (
        !$past(i_rst) && $changed(o_sleep_done_flag) |-> $rose(o_clk_run)) else $error("done");
    wfi_gate_a: assert property (
        o_clk_run && i_wfi_req && !i_irq_pending ##1 o_clk_run |-> !o_core_clk_en)
        else $error("wfi");
    irq_resume_a: assert property (
        o_clk_run && i_irq_pending ##1 o_clk_run |-> o_core_clk_en) else $error("irq");
    sleep_hold_a: assert property (
        o_in_deep_sleep |-> !o_core_clk_en && o_mod_clk_en == '0 && $stable(o_sleep_done_flag))
        else $error("sleep state");
endmodule
bind dss_deep_sleep_sequencer dss_seq_assertions #(.N_MOD(N_MOD), .SETTLE_CYC(SETTLE_CYC))
    i_dss_seq_assertions (
        .i_clk             (i_clk),
        .i_rst             (i_rst),
        .i_sleep_wake_pin  (i_sleep_wake_pin),
        .i_sleep_arm_bit   (i_sleep_arm_bit),
        .i_wfi_req         (i_wfi_req),
        .i_irq_pending     (i_irq_pending),
        .o_sleep_done_flag (o_sleep_done_flag),
        .o_clk_run         (o_clk_run),
        .o_osc_pwr_on      (o_osc_pwr_on),
        .o_core_clk_en     (o_core_clk_en),
        .o_mod_clk_en      (o_mod_clk_en),
        .o_in_deep_sleep   (o_in_deep_sleep));

/* sim/dss_wake_ctl.sv */
`timescale 1ns/1ps
module dss_wake_ctl #(
    parameter int LOW_MIN = 20
) (
    input  wire logic i_clk,
    input  wire logic i_sleep_req,
    output logic      o_pin = 1'h1
);
    int   low_cnt = 0;
    logic req_q   = 1'h0;
    // Request taken on the rising edge so a falling-edge bench write cannot race
    always @(posedge i_clk) begin
        req_q <= i_sleep_req;
    end
    // Falls on request, rises only after the minimum low time
    always @(negedge i_clk) begin
        low_cnt <= o_pin ? 0 : low_cnt + 1;
        o_pin <= req_q ? 1'h0 : (low_cnt >= LOW_MIN) ? 1'h1 : o_pin;
    end
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb_top;
    import dss_pkg::*;
    localparam int ST = 4;
    logic       i_clk = 1'h0, i_rst = 1'h1, i_sleep_wake_pin, sleep_req = 1'h0;
    logic       i_sleep_arm_bit = 1'h0, i_wfi_req = 1'h0, i_irq_pending = 1'h0;
    logic       i_pll_bypass = 1'h0, i_pll_pwr_off_req = 1'h0;
    logic [7:0] i_mod_clk_en = 8'h0F, i_mod_keep_on = 8'h30, o_mod_clk_en;
    logic       o_sleep_done_flag, o_clk_run, o_osc_pwr_on, o_core_clk_en;
    logic       o_pll_sel_ref, o_pll_pwr_on, o_in_deep_sleep;
    int         mismatches = 0, n_checks = 0;
    // Sequencer and wake pin driver
    dss_deep_sleep_sequencer #(.SETTLE_CYC(ST)) i_dss_deep_sleep_sequencer (
        .i_clk             (i_clk),
        .i_rst             (i_rst),
        .i_sleep_wake_pin  (i_sleep_wake_pin),
        .i_sleep_arm_bit   (i_sleep_arm_bit),
        .i_wfi_req         (i_wfi_req),
        .i_irq_pending     (i_irq_pending),
        .i_mod_clk_en      (i_mod_clk_en),
        .i_mod_keep_on     (i_mod_keep_on),
        .i_pll_bypass      (i_pll_bypass),
        .i_pll_pwr_off_req (i_pll_pwr_off_req),
        .o_sleep_done_flag (o_sleep_done_flag),
        .o_clk_run         (o_clk_run),
        .o_osc_pwr_on      (o_osc_pwr_on),
        .o_core_clk_en     (o_core_clk_en),
        .o_mod_clk_en      (o_mod_clk_en),
        .o_pll_sel_ref     (o_pll_sel_ref),
        .o_pll_pwr_on      (o_pll_pwr_on),
        .o_in_deep_sleep   (o_in_deep_sleep));
    dss_wake_ctl #(.LOW_MIN(WAKE_LOW_MIN_CYC)) i_dss_wake_ctl (.i_clk(i_clk),
        .i_sleep_req(sleep_req), .o_pin(i_sleep_wake_pin));
    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;
    // Cycle ceiling against hangs
    initial begin
        repeat (3000) @(posedge i_clk);
        mismatches++;
        conclude();
    end
    task automatic conclude();
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Core gating, module enables, PLL controls
    task automatic t_ctl();
        i_wfi_req = 1'h1;
        i_pll_bypass = 1'h1;
        repeat (2) @(negedge i_clk);
        `CHK(o_core_clk_en, 1'h0)
        `CHK(o_mod_clk_en, 8'h3F)
        `CHK({o_pll_sel_ref, o_pll_pwr_on}, 2'h3)
        i_irq_pending = 1'h1;
        i_pll_pwr_off_req = 1'h1;
        i_mod_clk_en = 8'h00;
        @(negedge i_clk);
        `CHK(o_core_clk_en, 1'h1)
        `CHK(o_mod_clk_en, 8'h30)
        `CHK({o_pll_sel_ref, o_pll_pwr_on}, 2'h2)
        {i_wfi_req, i_irq_pending, i_pll_bypass} = 3'h0;
        i_mod_clk_en = 8'h0F;
    endtask
    // One sleep request, ignored when disarmed
    task automatic t_sleep(input logic armed);
        logic d0;
        int   k;
        d0 = o_sleep_done_flag;
        i_sleep_arm_bit = armed;
        sleep_req = 1'h1;
        for (k = 0; k < 40 && o_in_deep_sleep !== 1'h1; k++) @(negedge i_clk);
        `CHK(o_in_deep_sleep, armed)
        `CHK({o_clk_run, o_osc_pwr_on}, {!armed, !armed})
        `CHK(o_mod_clk_en, armed ? 8'h00 : 8'h3F)
        sleep_req = 1'h0;
        for (k = 0; k < 60 && o_osc_pwr_on !== 1'h1; k++) @(negedge i_clk);
        for (k = 0; k < 60 && o_clk_run !== 1'h1; k++) @(negedge i_clk);
        `CHK(k > ST, armed)
        `CHK(o_sleep_done_flag, d0 ^ armed)
        `CHK({o_core_clk_en, o_mod_clk_en, o_pll_sel_ref, o_pll_pwr_on}, 11'h4FD)
        i_sleep_arm_bit = 1'h0;
        repeat (25) @(negedge i_clk);
    endtask
    // Reset, then each scenario in turn
    initial begin
        repeat (20) @(negedge i_clk);
        i_rst = 1'h0;
        t_ctl();
        t_sleep(1'h0);
        t_sleep(1'h1);
        t_sleep(1'h1);
        conclude();
    end
endmodule
